// ---- logic/zcd_pkg.sv ----
// Constants shared by the crossing detector logic and its register port
package zcd_pkg;

   // ********************
   // Bus widths
   // ********************
   localparam int ADDR_W = 16;  // Byte address width on the bus
   localparam int BUS_W  = 32;  // Bus data width
   localparam int REG_W  = 8;   // Register width in the low lane

   // ********************
   // Register indices and byte addresses (index times four)
   // ********************
   localparam logic [ADDR_W-1:0] CTRL_IDX  = 16'h0f32;
   localparam logic [ADDR_W-1:0] FLAG_IDX  = 16'h0f33;
   localparam logic [ADDR_W-1:0] PDIS_IDX  = 16'h0f34;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[13:0], 2'b00};
   localparam logic [ADDR_W-1:0] FLAG_ADDR = {FLAG_IDX[13:0], 2'b00};
   localparam logic [ADDR_W-1:0] PDIS_ADDR = {PDIS_IDX[13:0], 2'b00};

   // ********************
   // Field positions
   // ********************
   localparam int SOFT_EN_BIT = 7;  // Software enable
   localparam int OUT_BIT     = 5;  // Read-only logic output
   localparam int INVERT_BIT  = 4;  // Output polarity
   localparam int RISE_EN_BIT = 1;  // Rising edge flag enable
   localparam int FALL_EN_BIT = 0;  // Falling edge flag enable
   localparam int FLAG_BIT    = 0;  // Crossing flag, write 1 clears
   localparam int MDIS_BIT    = 0;  // Module disable bit

   // ********************
   // Reset values and bus answers
   // ********************
   localparam logic       CTRL_RST = 1'b0;  // All control fields
   localparam logic       FUSE_RST = 1'b1;  // Fuse before capture
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- logic/reg_port_if.sv ----
// Internal register access port between bus slave and detector core
interface reg_port_if;
   import zcd_pkg::*;
   logic              wr_en;    // One-cycle register write strobe
   logic [ADDR_W-1:0] wr_addr;  // Write byte address
   logic [REG_W-1:0]  wr_data;  // Write data, low lane
   logic              wr_hit;   // Write address is mapped
   logic [ADDR_W-1:0] rd_addr;  // Read byte address
   logic [REG_W-1:0]  rd_data;  // Read data, low lane
   logic              rd_hit;   // Read address is mapped

   // Bus side drives addresses and strobe
   modport bus  (output wr_en, wr_addr, wr_data, rd_addr,
                 input  wr_hit, rd_data, rd_hit);
   // Core side decodes and answers
   modport core (input  wr_en, wr_addr, wr_data, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface

// ---- logic/level_sync.sv ----
// Three-stage synchroniser with agreement filter for a pin level
module level_sync
   import zcd_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      level_out
);

   logic [2:0] stage_reg;   // Synchroniser chain
   logic [2:0] stage_next;
   logic       level_reg;   // Accepted level
   logic       level_next;

   // ********************
   // Next state: accept a change once stages two and three agree
   // ********************
   always_comb begin
      stage_next = {stage_reg[1:0], async_in};
      level_next = level_reg;
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
   end

   // Registers only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stage_reg <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;

endmodule

// ---- logic/axil_reg_slave.sv ----
// AXI4-Lite slave that turns bus transfers into register port accesses
module axil_reg_slave
   import zcd_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [BUS_W-1:0]  wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [BUS_W-1:0]       rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   reg_port_if.bus                port
);

   logic              awr_reg, awr_next;    // Write address ready
   logic              wr_reg, wr_next;      // Write data ready
   logic              awh_reg, awh_next;    // Write address held
   logic              wh_reg, wh_next;      // Write data held
   logic [ADDR_W-1:0] wa_reg, wa_next;      // Held write address
   logic [REG_W-1:0]  wd_reg, wd_next;      // Held write data
   logic              ws_reg, ws_next;      // Held low lane strobe
   logic              bv_reg, bv_next;      // Write response valid
   logic [1:0]        br_reg, br_next;      // Write response code
   logic              arr_reg, arr_next;    // Read address ready
   logic              arh_reg, arh_next;    // Read address held
   logic [ADDR_W-1:0] ra_reg, ra_next;      // Held read address
   logic              rv_reg, rv_next;      // Read data valid
   logic [REG_W-1:0]  rd_reg, rd_next;      // Read data
   logic [1:0]        rr_reg, rr_next;      // Read response code
   logic              wr_go;                // Both halves held

   assign wr_go = awh_reg && wh_reg && !bv_reg;

   // ************************************************************
   // Write channel: address and data in either order
   // ************************************************************
   always_comb begin
      awr_next = awr_reg;
      wr_next  = wr_reg;
      awh_next = awh_reg;
      wh_next  = wh_reg;
      wa_next  = wa_reg;
      wd_next  = wd_reg;
      ws_next  = ws_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      if (awvalid && awr_reg) begin
         awh_next = 1'b1;
         awr_next = 1'b0;
         wa_next  = awaddr;
      end
      if (wvalid && wr_reg) begin
         wh_next = 1'b1;
         wr_next = 1'b0;
         wd_next = wdata[REG_W-1:0];
         ws_next = wstrb[0];
      end
      if (wr_go) begin
         // Register written in this cycle, answer next
         bv_next  = 1'b1;
         br_next  = port.wr_hit ? RESP_OKAY : RESP_SLVERR;
         awh_next = 1'b0;
         wh_next  = 1'b0;
      end
      if (bv_reg && bready) begin
         bv_next  = 1'b0;
         awr_next = 1'b1;
         wr_next  = 1'b1;
      end
   end

   // ************************************************************
   // Read channel: one read at a time, data two cycles after taking
   // ************************************************************
   always_comb begin
      arr_next = arr_reg;
      arh_next = arh_reg;
      ra_next  = ra_reg;
      rv_next  = rv_reg;
      rd_next  = rd_reg;
      rr_next  = rr_reg;
      if (arvalid && arr_reg) begin
         arh_next = 1'b1;
         arr_next = 1'b0;
         ra_next  = araddr;
      end
      if (arh_reg) begin
         arh_next = 1'b0;
         rv_next  = 1'b1;
         rd_next  = port.rd_data;
         rr_next  = port.rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rv_reg && rready) begin
         rv_next  = 1'b0;
         arr_next = 1'b1;
      end
   end

   // Registers only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awr_reg <= 1'b1;
         wr_reg  <= 1'b1;
         awh_reg <= 1'b0;
         wh_reg  <= 1'b0;
         wa_reg  <= '0;
         wd_reg  <= '0;
         ws_reg  <= 1'b0;
         bv_reg  <= 1'b0;
         br_reg  <= RESP_OKAY;
         arr_reg <= 1'b1;
         arh_reg <= 1'b0;
         ra_reg  <= '0;
         rv_reg  <= 1'b0;
         rd_reg  <= '0;
         rr_reg  <= RESP_OKAY;
      end else begin
         awr_reg <= awr_next;
         wr_reg  <= wr_next;
         awh_reg <= awh_next;
         wh_reg  <= wh_next;
         wa_reg  <= wa_next;
         wd_reg  <= wd_next;
         ws_reg  <= ws_next;
         bv_reg  <= bv_next;
         br_reg  <= br_next;
         arr_reg <= arr_next;
         arh_reg <= arh_next;
         ra_reg  <= ra_next;
         rv_reg  <= rv_next;
         rd_reg  <= rd_next;
         rr_reg  <= rr_next;
      end
   end

   // Register port and bus outputs
   assign port.wr_en   = wr_go && ws_reg;
   assign port.wr_addr = wa_reg;
   assign port.wr_data = wd_reg;
   assign port.rd_addr = ra_reg;
   assign awready = awr_reg;
   assign wready  = wr_reg;
   assign bvalid  = bv_reg;
   assign bresp   = br_reg;
   assign arready = arr_reg;
   assign rvalid  = rv_reg;
   assign rresp   = rr_reg;
   assign rdata   = {{(BUS_W-REG_W){1'b0}}, rd_reg};

endmodule

// ---- logic/crossing_detector.sv ----
// Crossing detector control, status and edge flag logic with bus port
// What this block does
// - Detector and edge flags run during sleep
// - Fuse zero: detector active from the second clock after reset release
// - Fuse zero: always enabled, soft enable ignored
// - Fuse one, enable set: drive source/sink
// - Fuse one, enable clear: normal pin control
// - Module disable bit can switch detector off
// - Bit 5 shows sinking, per polarity
// - Bit 4 inverts output; edges follow it
// - Rising enable sets flag on rising output
// - Falling enable sets flag on falling output
// - Control fields reset to zero, enable bit 7
// - Edge during flag clear leaves flag set
// - Polarity change raises flag, any enable
//
// Added by the designer: the AXI4-Lite register port.
module crossing_detector
   import zcd_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   // AXI4-Lite register bus
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [BUS_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [BUS_W-1:0]       s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Analogue and configuration side
   input  wire logic              comp_sinking,
   input  wire logic              config_fuse_n,
   output logic                   pin_source_sink_en,
   output logic                   crossing_logic_out,
   output logic                   crossing_irq_flag
);

   // ********************
   // Declarations
   // ********************
   reg_port_if port ();                 // Slave to core access port

   logic sink_level;                    // Filtered comparator state
   logic fuse_reg, fuse_next;           // Captured fuse level
   logic fuse_seen_reg, fuse_seen_next; // Fuse has been captured
   logic soft_en_reg, soft_en_next;     // Software enable
   logic invert_reg, invert_next;       // Output polarity
   logic rise_en_reg, rise_en_next;     // Rising edge enable
   logic fall_en_reg, fall_en_next;     // Falling edge enable
   logic mdis_reg, mdis_next;           // Module disable bit
   logic flag_reg, flag_next;           // Crossing flag
   logic out_reg, out_next;             // Polarity adjusted output
   logic act_reg, act_next;             // Detector active
   logic active;                        // Enable decision
   logic raw_out;                       // Gated, adjusted output
   logic rise_evt;                      // Enabled rising edge
   logic fall_evt;                      // Enabled falling edge
   logic inv_evt;                       // Polarity was rewritten
   logic flag_set;                      // Any flag setting event
   logic flag_clr;                      // Software clear request
   logic wr_ctrl;                       // Write to control register
   logic wr_flag;                       // Write to flag register
   logic wr_pdis;                       // Write to disable register

   // ********************
   // Bus slave and comparator synchroniser
   // ********************
   axil_reg_slave u_slave (
      .clock   (clock),
      .rst_n   (rst_n),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .port    (port)
   );

   // Comparator is asynchronous to the clock
   level_sync u_sync (
      .clock     (clock),
      .rst_n     (rst_n),
      .async_in  (comp_sinking),
      .level_out (sink_level)
   );

   // ********************
   // Address decode
   // ********************
   assign wr_ctrl = port.wr_en && (port.wr_addr == CTRL_ADDR);
   assign wr_flag = port.wr_en && (port.wr_addr == FLAG_ADDR);
   assign wr_pdis = port.wr_en && (port.wr_addr == PDIS_ADDR);

   // Mapped write addresses answer okay
   assign port.wr_hit = (port.wr_addr == CTRL_ADDR) ||
                        (port.wr_addr == FLAG_ADDR) ||
                        (port.wr_addr == PDIS_ADDR);

   // Read mux, unused bits read zero
   always_comb begin
      port.rd_data = '0;
      port.rd_hit  = 1'b1;
      unique case (port.rd_addr)
         CTRL_ADDR: begin
            port.rd_data[SOFT_EN_BIT] = soft_en_reg;
            port.rd_data[OUT_BIT]     = out_reg;
            port.rd_data[INVERT_BIT]  = invert_reg;
            port.rd_data[RISE_EN_BIT] = rise_en_reg;
            port.rd_data[FALL_EN_BIT] = fall_en_reg;
         end
         FLAG_ADDR: begin
            port.rd_data[FLAG_BIT] = flag_reg;
         end
         PDIS_ADDR: begin
            port.rd_data[MDIS_BIT] = mdis_reg;
         end
         default: begin
            port.rd_hit = 1'b0;                      // Unmapped
         end
      endcase
   end

   // ********************
   // Fuse capture, once after reset release
   // ********************
   always_comb begin
      fuse_next      = fuse_reg;
      fuse_seen_next = 1'b1;
      if (!fuse_seen_reg) begin
         fuse_next = config_fuse_n;
      end
   end

   // ********************
   // Software writable control and disable fields
   // ********************
   always_comb begin
      soft_en_next = soft_en_reg;
      invert_next  = invert_reg;
      rise_en_next = rise_en_reg;
      fall_en_next = fall_en_reg;
      mdis_next    = mdis_reg;
      if (wr_ctrl) begin
         soft_en_next = port.wr_data[SOFT_EN_BIT];
         invert_next  = port.wr_data[INVERT_BIT];
         rise_en_next = port.wr_data[RISE_EN_BIT];
         fall_en_next = port.wr_data[FALL_EN_BIT];
      end
      if (wr_pdis) begin
         mdis_next = port.wr_data[MDIS_BIT];
      end
   end

   // ********************
   // Enable decision
   // ********************
   always_comb begin
      if (!fuse_reg) begin
         // Fuse clear: always on, enable and disable ignored
         active = 1'b1;
      end else begin
         // Fuse set: software enable, unless module disabled
         active = soft_en_reg && !mdis_reg;
      end
   end

   // ********************
   // Logic output and edge events
   // ********************
   // Inactive detector presents a low sink level
   assign raw_out  = (active && sink_level) ^ invert_next;
   assign rise_evt = rise_en_reg && raw_out && !out_reg;
   assign fall_evt = fall_en_reg && !raw_out && out_reg;
   assign inv_evt  = wr_ctrl && (invert_next != invert_reg);
   assign flag_set = rise_evt || fall_evt || inv_evt;
   assign flag_clr = wr_flag && port.wr_data[FLAG_BIT];

   // Output, pin drive and flag next values
   always_comb begin
      out_next  = raw_out;
      // Enable low returns the pin to normal control
      act_next  = active;
      // Set beats a clear in the same cycle
      flag_next = flag_set || (flag_reg && !flag_clr);
   end

   // ********************
   // Registers; no sleep gating, so edges keep flagging
   // ********************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fuse_reg      <= FUSE_RST;
         fuse_seen_reg <= 1'b0;
         soft_en_reg   <= CTRL_RST;
         invert_reg    <= CTRL_RST;
         rise_en_reg   <= CTRL_RST;
         fall_en_reg   <= CTRL_RST;
         mdis_reg      <= CTRL_RST;
         flag_reg      <= 1'b0;
         out_reg       <= 1'b0;
         act_reg       <= 1'b0;
      end else begin
         fuse_reg      <= fuse_next;
         fuse_seen_reg <= fuse_seen_next;
         soft_en_reg   <= soft_en_next;
         invert_reg    <= invert_next;
         rise_en_reg   <= rise_en_next;
         fall_en_reg   <= fall_en_next;
         mdis_reg      <= mdis_next;
         flag_reg      <= flag_next;
         out_reg       <= out_next;
         act_reg       <= act_next;
      end
   end

   // ********************
   // Outputs straight from flip-flops
   // ********************
   assign pin_source_sink_en = act_reg;
   assign crossing_logic_out = out_reg;
   assign crossing_irq_flag  = flag_reg;

endmodule

// ---- tb/zero_cross_assertions.sv ----
// Port checks for the crossing detector
module zero_cross_assertions
   import zcd_pkg::*;
(
   input wire logic             clock,
   input wire logic             rst_n,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [BUS_W-1:0] s_axi_rdata,
   input wire logic             comp_sinking,
   input wire logic             config_fuse_n,
   input wire logic             pin_source_sink_en,
   input wire logic             crossing_logic_out,
   input wire logic             crossing_irq_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ***
   // Helper counters
   // ***
   logic [3:0] calm_reg, calm_next;  // Cycles since comparator or pin enable moved
   logic [2:0] up_reg, up_next;      // Cycles since reset release
   logic       comp_reg, en_reg;     // Last comparator and pin levels
   // Saturating counts
   always_comb begin
      calm_next = (calm_reg == 4'hf) ? calm_reg : calm_reg + 4'h1;
      if (comp_sinking != comp_reg || pin_source_sink_en != en_reg) begin
         calm_next = 4'h0;
      end
      up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
   end
   // Register helpers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         calm_reg <= 4'h0;
         up_reg   <= 3'h0;
         comp_reg <= 1'b0;
         en_reg   <= 1'b0;
      end else begin
         calm_reg <= calm_next;
         up_reg   <= up_next;
         comp_reg <= comp_sinking;
         en_reg   <= pin_source_sink_en;
      end
   end
   // ***
   // Bus steps
   // ***
   sequence w_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_w_answer:
      assert property (w_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late or early");
   a_r_answer:
      assert property (ar_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer late or early");
   a_b_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_r_hold:
      assert property (s_axi_rvalid && !s_axi_rready
                       |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   a_busy_readies:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write readies up while answering");
   a_rdata_lanes:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   // ***
   // Detector
   // ***
   a_fuse_on:
      assert property (up_reg >= 3'd3 && !config_fuse_n
                       |-> pin_source_sink_en)
      else $error("detector off with fuse clear");
   a_flag_cause:
      assert property ($rose(crossing_irq_flag)
                       |-> $changed(crossing_logic_out))
      else $error("flag set without output change");
   a_flag_clear:
      assert property ($fell(crossing_irq_flag) |-> s_axi_bvalid)
      else $error("flag fell without a write");
   a_out_cause:
      assert property ($changed(crossing_logic_out) && !s_axi_bvalid
                       |-> calm_reg <= 4'd10)
      else $error("output moved without a cause");
endmodule

// ---- tb/comp_source_model.sv ----
// Behavioural comparator seen through the detector pin
module comp_source_model #(
   parameter int DELAY_NS = 13  // Comparator answer delay
) (
   input  wire logic pin_source_sink_en,
   input  wire logic want_sink,
   output logic      comp_sinking
);
   timeunit 1ns;
   timeprecision 100ps;
   initial comp_sinking = 1'b0;
   // Pin held: comparator follows the waveform after a delay
   always @(want_sink or pin_source_sink_en)
      if (pin_source_sink_en) comp_sinking <= #(DELAY_NS) want_sink;
   // Pin released: comparator chatters, no settled level
   always #17 if (!pin_source_sink_en) comp_sinking = ~comp_sinking;
endmodule

// ---- tb/zero_cross_detect_logic_tb.sv ----
// Self-checking bench for the crossing detector
`define CHK(nm, g, e) begin n_compared++; \
   if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module zero_cross_detect_logic_tb
   import zcd_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, rst_n, fuse_n, want, lvl;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, e_d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, e_r, en;
   logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
   logic        comp, pin_en, out_lvl, flag;
   logic [31:0] rq_d[$];              // Expected read data
   logic [1:0]  rq_r[$], bq[$];       // Expected responses
   int          miscompares, n_compared;
   integer      seed = 32'h9884;      // Random seed
   crossing_detector crossing_detector_inst (.clock, .rst_n,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .comp_sinking(comp),
      .config_fuse_n(fuse_n), .pin_source_sink_en(pin_en),
      .crossing_logic_out(out_lvl), .crossing_irq_flag(flag));
   comp_source_model #(.DELAY_NS(13)) comp_source_model_inst (
      .pin_source_sink_en(pin_en), .want_sink(want), .comp_sinking(comp));
   // Clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Bus write, random answer stall
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      logic ap = 1'b1, dp = 1'b1;
      bq.push_back(r);
      @(posedge clock);
      awaddr <= a; wdata <= {24'($random(seed)), d}; wstrb <= s;
      awv <= 1'b1; wv <= 1'b1;
      while (ap || dp) begin
         @(posedge clock);
         if (ap && awr) begin ap = 1'b0; awv <= 1'b0; end
         if (dp && wrdy) begin dp = 1'b0; wv <= 1'b0; end
      end
      repeat (2'($random(seed)) % 3) @(posedge clock);
      br <= 1'b1;
      do @(posedge clock); while (!bv);
      br <= 1'b0;
   endtask
   // Bus read, random answer stall
   task automatic rd(input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      rq_d.push_back(d); rq_r.push_back(r);
      @(posedge clock);
      araddr <= a; arv <= 1'b1;
      do @(posedge clock); while (!arr);
      arv <= 1'b0;
      repeat (2'($random(seed)) % 3) @(posedge clock);
      rr <= 1'b1;
      do @(posedge clock); while (!rv);
      rr <= 1'b0;
   endtask
   // Answer monitor takes the oldest note
   always @(posedge clock) begin
      if (bv && br) begin
         e_r = bq.pop_front();
         `CHK("bresp", bresp, e_r)
      end
      if (rv && rr) begin
         e_d = rq_d.pop_front();
         e_r = rq_r.pop_front();
         `CHK("rdata", rdata, e_d)
         `CHK("rresp", rresp, e_r)
      end
   end
   task automatic final_report;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      final_report;
   end
   // Main sequence
   initial begin
      rst_n = 0; fuse_n = 1; want = 0; lvl = 0; awaddr = 0; araddr = 0;
      wdata = 0; wstrb = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values, unmapped place, refused lane
      rd(CTRL_ADDR, 32'h0, RESP_OKAY);
      rd(PDIS_ADDR, 32'h0, RESP_OKAY);
      wr(16'h0004, 8'hff, 4'hf, RESP_SLVERR);
      rd(16'h0004, 32'h0, RESP_SLVERR);
      wr(CTRL_ADDR, 8'h80, 4'he, RESP_OKAY);
      rd(CTRL_ADDR, 32'h0, RESP_OKAY);
      `CHK("pin_en", pin_en, 1'b0)
      // Enable, then edges under random enables
      wr(CTRL_ADDR, 8'h80, 4'h1, RESP_OKAY);
      repeat (10) @(posedge clock);
      `CHK("pin_en", pin_en, 1'b1)
      for (int i = 0; i < 8; i++) begin
         en = 2'($random(seed));
         wr(CTRL_ADDR, {6'h20, en}, 4'h1, RESP_OKAY);
         wr(FLAG_ADDR, 8'h01, 4'h1, RESP_OKAY);
         lvl = ~lvl;
         want <= lvl;
         repeat (8) @(posedge clock);
         rd(FLAG_ADDR, {31'h0, lvl ? en[1] : en[0]}, RESP_OKAY);
         rd(CTRL_ADDR, {24'h0, 2'b10, lvl, 3'h0, en}, RESP_OKAY);
      end
      // Polarity write and inverted edges
      wr(FLAG_ADDR, 8'h01, 4'h1, RESP_OKAY);
      wr(CTRL_ADDR, 8'h92, 4'h1, RESP_OKAY);
      rd(FLAG_ADDR, 32'h1, RESP_OKAY);
      rd(CTRL_ADDR, 32'hb2, RESP_OKAY);
      wr(FLAG_ADDR, 8'h01, 4'h1, RESP_OKAY);
      want <= 1'b1;
      repeat (8) @(posedge clock);
      rd(FLAG_ADDR, 32'h0, RESP_OKAY);
      want <= 1'b0;
      repeat (8) @(posedge clock);
      rd(FLAG_ADDR, 32'h1, RESP_OKAY);
      // Module disable, then soft disable with polarity change
      wr(PDIS_ADDR, 8'h01, 4'h1, RESP_OKAY);
      @(negedge clock);
      `CHK("pin_en", pin_en, 1'b0)
      rd(PDIS_ADDR, 32'h1, RESP_OKAY);
      rd(CTRL_ADDR, 32'hb2, RESP_OKAY);
      wr(PDIS_ADDR, 8'h00, 4'h1, RESP_OKAY);
      wr(FLAG_ADDR, 8'h01, 4'h1, RESP_OKAY);
      wr(CTRL_ADDR, 8'h00, 4'h1, RESP_OKAY);
      rd(FLAG_ADDR, 32'h1, RESP_OKAY);
      `CHK("pin_en", pin_en, 1'b0)
      // Fuse clear: always active
      rst_n <= 1'b0;
      fuse_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (6) @(posedge clock);
      `CHK("pin_en", pin_en, 1'b1)
      wr(CTRL_ADDR, 8'h00, 4'h1, RESP_OKAY);
      wr(PDIS_ADDR, 8'h01, 4'h1, RESP_OKAY);
      `CHK("pin_en", pin_en, 1'b1)
      want <= 1'b1;
      repeat (8) @(posedge clock);
      rd(CTRL_ADDR, 32'h20, RESP_OKAY);
      final_report;
   end
endmodule
bind crossing_detector zero_cross_assertions zero_cross_assertions_inst (
   .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .comp_sinking, .config_fuse_n, .pin_source_sink_en,
   .crossing_logic_out, .crossing_irq_flag);
